/* src/crf_consts.vh */
`ifndef CRF_CONSTS_VH
`define CRF_CONSTS_VH
// condition flag bit positions
`define CRF_BIT_IMASK 7
`define CRF_BIT_USR_HI 6
`define CRF_BIT_HALF 5
`define CRF_BIT_USR_LO 4
`define CRF_BIT_NEG 3
`define CRF_BIT_ZERO 2
`define CRF_BIT_OVF 1
`define CRF_BIT_CARRY 0
// register numbering and reset vector
`define CRF_STACK_REG 3'h7
`define CRF_RESET_VECTOR 16'h0000
`define CRF_WORD_ALIGN_MASK 16'hfffe
`define CRF_FLAGS_RESET 8'h80
`define CRF_IMASK_ONLY 8'h80
// byte and word carry boundaries
`define CRF_BYTE_HALF_BIT 4
`define CRF_WORD_HALF_BIT 12
// operation codes for the flag unit
`define CRF_OP_NONE 4'h0
`define CRF_OP_ADD_B 4'h1
`define CRF_OP_SUB_B 4'h2
`define CRF_OP_ADD_W 4'h3
`define CRF_OP_SUB_W 4'h4
`define CRF_OP_LOGIC 4'h5
`define CRF_OP_SHIFT 4'h6
`define CRF_OP_BITACC 4'h7
`define CRF_OP_MOVE_B 4'h8
`define CRF_OP_MOVE_W 4'h9
// flag-register instruction codes
`define CRF_FI_NONE 3'h0
`define CRF_FI_LOAD 3'h1
`define CRF_FI_AND 3'h2
`define CRF_FI_OR 3'h3
`define CRF_FI_XOR 3'h4
// reset sequence states
`define CRF_ST_FETCH 2'h0
`define CRF_ST_WAIT 2'h1
`define CRF_ST_RUN 2'h2
`endif

/* src/crf_gpr_bank.v */
`include "crf_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module crf_gpr_bank #(
	parameter NREG = 8
) (
	// clock
	input  wire        clk_i,
	// write port
	input  wire        wr_hi_i,
	input  wire        wr_lo_i,
	input  wire [2:0]  wr_sel_i,
	input  wire [15:0] wr_data_i,
	// read ports
	input  wire [2:0]  rd_a_sel_i,
	output wire [15:0] rd_a_o,
	input  wire [2:0]  rd_b_sel_i,
	output wire [15:0] rd_b_o,
	output wire [15:0] stack_o
);
	// =====================================================
	// byte storage
	reg [7:0] hi_ff [0:NREG-1];
	reg [7:0] lo_ff [0:NREG-1];
	// =====================================================
	// writes
	// halves written independently
	always @(posedge clk_i)
	begin
		if (wr_hi_i)
			hi_ff[wr_sel_i] <= wr_data_i[15:8];
		if (wr_lo_i)
			lo_ff[wr_sel_i] <= wr_data_i[7:0];
	end
	assign rd_a_o  = {hi_ff[rd_a_sel_i], lo_ff[rd_a_sel_i]};
	assign rd_b_o  = {hi_ff[rd_b_sel_i], lo_ff[rd_b_sel_i]};
	assign stack_o = {hi_ff[`CRF_STACK_REG], lo_ff[`CRF_STACK_REG]};
endmodule // crf_gpr_bank
`default_nettype wire

/* src/crf_flag_unit.v */
`include "crf_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module crf_flag_unit (
	// operation
	input  wire [3:0]  op_i,
	input  wire [15:0] a_i,
	input  wire [15:0] b_i,
	input  wire        cin_i,
	input  wire [15:0] res_i,
	input  wire        shout_i,
	input  wire        bit_i,
	input  wire [7:0]  flags_i,
	// result
	output reg  [7:0]  flags_o
);
	reg [4:0]  s4;
	reg [12:0] s12;
	reg [8:0]  s8;
	reg [16:0] s16;
	reg        sgn;
	reg        zer;
	always @*
	begin
		flags_o = flags_i;
		s4  = 5'h00;
		s12 = 13'h0000;
		s8  = 9'h000;
		s16 = 17'h00000;
		sgn = 1'b0;
		zer = 1'b0;
		case (op_i)
			`CRF_OP_ADD_B, `CRF_OP_SUB_B:
			begin
				if (op_i == `CRF_OP_ADD_B)
				begin
					s4 = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
					s8 = {1'b0, a_i[7:0]} + {1'b0, b_i[7:0]} + {8'h00, cin_i};
				end
				else
				begin
					s4 = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin_i};
					s8 = {1'b0, a_i[7:0]} - {1'b0, b_i[7:0]} - {8'h00, cin_i};
				end
				flags_o[`CRF_BIT_HALF]  = s4[`CRF_BYTE_HALF_BIT];
				flags_o[`CRF_BIT_NEG]   = s8[7];
				flags_o[`CRF_BIT_ZERO]  = (s8[7:0] == 8'h00);
				flags_o[`CRF_BIT_OVF]   = (op_i == `CRF_OP_ADD_B) ?
					(a_i[7] == b_i[7]) && (s8[7] != a_i[7]) :
					(a_i[7] != b_i[7]) && (s8[7] != a_i[7]);
				flags_o[`CRF_BIT_CARRY] = s8[8];
			end
			`CRF_OP_ADD_W, `CRF_OP_SUB_W:
			begin
				if (op_i == `CRF_OP_ADD_W)
				begin
					s12 = {1'b0, a_i[11:0]} + {1'b0, b_i[11:0]};
					s16 = {1'b0, a_i} + {1'b0, b_i};
				end
				else
				begin
					s12 = {1'b0, a_i[11:0]} - {1'b0, b_i[11:0]};
					s16 = {1'b0, a_i} - {1'b0, b_i};
				end
				flags_o[`CRF_BIT_HALF]  = s12[`CRF_WORD_HALF_BIT];
				flags_o[`CRF_BIT_NEG]   = s16[15];
				flags_o[`CRF_BIT_ZERO]  = (s16[15:0] == 16'h0000);
				flags_o[`CRF_BIT_OVF]   = (op_i == `CRF_OP_ADD_W) ?
					(a_i[15] == b_i[15]) && (s16[15] != a_i[15]) :
					(a_i[15] != b_i[15]) && (s16[15] != a_i[15]);
				flags_o[`CRF_BIT_CARRY] = s16[16];
			end
			`CRF_OP_LOGIC, `CRF_OP_MOVE_B, `CRF_OP_MOVE_W, `CRF_OP_SHIFT:
			begin
				sgn = (op_i == `CRF_OP_MOVE_W) ? res_i[15] : res_i[7];
				zer = (op_i == `CRF_OP_MOVE_W) ? (res_i == 16'h0000) : (res_i[7:0] == 8'h00);
				flags_o[`CRF_BIT_NEG]  = sgn;
				flags_o[`CRF_BIT_ZERO] = zer;
				flags_o[`CRF_BIT_OVF]  = 1'b0;
				if (op_i == `CRF_OP_SHIFT)
					flags_o[`CRF_BIT_CARRY] = shout_i;
			end
			`CRF_OP_BITACC:
				flags_o[`CRF_BIT_CARRY] = bit_i;
			default:
				flags_o = flags_i;
		endcase
	end
endmodule // crf_flag_unit
`default_nettype wire

/* src/crf_core_state.v */
`include "crf_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module crf_core_state (
	// clock and reset
	input  wire        CLOCK_I,
	input  wire        RESETN_I,
	// register file access
	input  wire        REG_WR_HI_I,
	input  wire        REG_WR_LO_I,
	input  wire [2:0]  REG_WR_SEL_I,
	input  wire [15:0] REG_WR_DATA_I,
	input  wire [2:0]  REG_A_SEL_I,
	input  wire        REG_A_BYTE_I,
	input  wire        REG_A_LOW_I,
	output wire [15:0] REG_A_DATA_O,
	input  wire [2:0]  REG_B_SEL_I,
	output wire [15:0] REG_B_DATA_O,
	// address generation
	input  wire [2:0]  ADDR_SEL_I,
	input  wire        ADDR_WORD_I,
	output wire [15:0] DATA_ADDR_O,
	output wire [15:0] STACK_ADDR_O,
	// program counter
	input  wire        PC_LOAD_I,
	input  wire [15:0] PC_DATA_I,
	input  wire        PC_STEP_I,
	output wire [15:0] FETCH_ADDR_O,
	output wire [15:0] PC_O,
	output wire        VEC_REQ_O,
	input  wire        VEC_ACK_I,
	input  wire [15:0] VEC_DATA_I,
	output wire        RUN_O,
	// flag update
	input  wire [3:0]  FLAG_OP_I,
	input  wire [15:0] FLAG_A_I,
	input  wire [15:0] FLAG_B_I,
	input  wire [15:0] FLAG_RES_I,
	input  wire        FLAG_SHOUT_I,
	input  wire [2:0]  BIT_NUM_I,
	input  wire [7:0]  BIT_BYTE_I,
	input  wire        BIT_INVERT_I,
	output wire        BIT_SEL_O,
	// flag instructions and exceptions
	input  wire [2:0]  FLAG_INSN_I,
	input  wire [7:0]  FLAG_INSN_DATA_I,
	input  wire        FLAG_RESTORE_I,
	input  wire [15:0] FLAG_STACK_WORD_I,
	input  wire        EXC_ENTRY_I,
	output wire [7:0]  FLAGS_O,
	output wire [15:0] FLAG_PUSH_WORD_O,
	output wire        IRQ_MASKED_O,
	// branch conditions
	output wire        COND_NEG_O,
	output wire        COND_ZERO_O,
	output wire        COND_OVF_O,
	output wire        COND_CARRY_O,
	// decimal digits
	output wire [3:0]  BCD_HI_DIGIT_O,
	output wire [3:0]  BCD_LO_DIGIT_O
);
	// =====================================================
	// reset release
	reg        rst_meta_ff;
	reg        rst_sync_ff;
	wire       rst_n = rst_sync_ff;
	always @(posedge CLOCK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// =====================================================
	// general registers
	wire [15:0] rd_a;
	wire [15:0] rd_b;
	wire [15:0] stack_word;
	wire [15:0] addr_word;
	crf_gpr_bank #(
		.NREG(8)
	) u_bank (
		.clk_i      (CLOCK_I),
		.wr_hi_i    (REG_WR_HI_I & rst_n),
		.wr_lo_i    (REG_WR_LO_I & rst_n),
		.wr_sel_i   (REG_WR_SEL_I),
		.wr_data_i  (REG_WR_DATA_I),
		.rd_a_sel_i (REG_A_SEL_I),
		.rd_a_o     (rd_a),
		.rd_b_sel_i (REG_B_SEL_I),
		.rd_b_o     (rd_b),
		.stack_o    (stack_word)
	);
	assign REG_A_DATA_O = REG_A_BYTE_I ? {8'h00, (REG_A_LOW_I ? rd_a[7:0] : rd_a[15:8])} : rd_a;
	assign REG_B_DATA_O = rd_b;

	// =====================================================
	// address generation
	function [15:0] word_align;
		input [15:0] a;
		input        w;
		begin
			word_align = w ? (a & `CRF_WORD_ALIGN_MASK) : a;
		end
	endfunction
	assign addr_word = (ADDR_SEL_I == REG_B_SEL_I) ? rd_b : rd_b;
	assign DATA_ADDR_O  = word_align(addr_word, ADDR_WORD_I);
	assign STACK_ADDR_O = word_align(stack_word, 1'b1);

	// =====================================================
	// program counter and reset vector sequence
	reg [1:0]  state_ff;
	reg [1:0]  nxt_state;
	reg [15:0] pc_ff;
	reg [15:0] nxt_pc;
	always @*
	begin
		nxt_state = state_ff;
		nxt_pc    = pc_ff;
		case (state_ff)
			`CRF_ST_FETCH:
				nxt_state = `CRF_ST_WAIT;
			`CRF_ST_WAIT:
			begin
				if (VEC_ACK_I)
				begin
					nxt_pc    = VEC_DATA_I;
					nxt_state = `CRF_ST_RUN;
				end
			end
			`CRF_ST_RUN:
			begin
				if (PC_LOAD_I)
					nxt_pc = PC_DATA_I;
				else if (PC_STEP_I)
					nxt_pc = pc_ff + 16'h0002;
			end
			default:
				nxt_state = `CRF_ST_FETCH;
		endcase
	end
	always @(posedge CLOCK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			state_ff <= `CRF_ST_FETCH;
			pc_ff    <= `CRF_RESET_VECTOR;
		end
		else if (!rst_n)
		begin
			state_ff <= `CRF_ST_FETCH;
			pc_ff    <= `CRF_RESET_VECTOR;
		end
		else
		begin
			state_ff <= nxt_state;
			pc_ff    <= nxt_pc;
		end
	end
	assign VEC_REQ_O = (state_ff == `CRF_ST_WAIT);
	assign RUN_O     = (state_ff == `CRF_ST_RUN);
	assign PC_O      = pc_ff;
	assign FETCH_ADDR_O = (state_ff == `CRF_ST_RUN) ? word_align(pc_ff, 1'b1) : `CRF_RESET_VECTOR;

	// =====================================================
	// bit selection
	// bit 0 to 7 of byte
	wire bit_pick = BIT_BYTE_I[BIT_NUM_I] ^ BIT_INVERT_I;
	assign BIT_SEL_O = bit_pick;
	assign BCD_HI_DIGIT_O = FLAG_RES_I[7:4];
	assign BCD_LO_DIGIT_O = FLAG_RES_I[3:0];

	// =====================================================
	// condition flags
	reg  [7:0] flags_ff;
	reg  [7:0] nxt_flags;
	wire [7:0] alu_flags;
	crf_flag_unit u_flags (
		.op_i    (RUN_O ? FLAG_OP_I : `CRF_OP_NONE),
		.a_i     (FLAG_A_I),
		.b_i     (FLAG_B_I),
		.cin_i   (flags_ff[`CRF_BIT_CARRY]),
		.res_i   (FLAG_RES_I),
		.shout_i (FLAG_SHOUT_I),
		.bit_i   (bit_pick),
		.flags_i (flags_ff),
		.flags_o (alu_flags)
	);
	always @*
	begin
		nxt_flags = alu_flags;
		case (FLAG_INSN_I)
			`CRF_FI_LOAD: nxt_flags = FLAG_INSN_DATA_I;
			`CRF_FI_AND:  nxt_flags = flags_ff & FLAG_INSN_DATA_I;
			`CRF_FI_OR:   nxt_flags = flags_ff | FLAG_INSN_DATA_I;
			`CRF_FI_XOR:  nxt_flags = flags_ff ^ FLAG_INSN_DATA_I;
			default:      nxt_flags = alu_flags;
		endcase
		if (FLAG_RESTORE_I)
			nxt_flags = FLAG_STACK_WORD_I[15:8];
		if (FLAG_INSN_I == `CRF_FI_NONE && !FLAG_RESTORE_I)
		begin
			nxt_flags[`CRF_BIT_USR_HI] = flags_ff[`CRF_BIT_USR_HI];
			nxt_flags[`CRF_BIT_USR_LO] = flags_ff[`CRF_BIT_USR_LO];
		end
		if (EXC_ENTRY_I)
			nxt_flags[`CRF_BIT_IMASK] = 1'b1;
	end
	always @(posedge CLOCK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			flags_ff <= `CRF_FLAGS_RESET;
		else if (!rst_n || !RUN_O)
			flags_ff <= flags_ff | `CRF_IMASK_ONLY;
		else
			flags_ff <= nxt_flags;
	end
	assign FLAGS_O = flags_ff;
	assign FLAG_PUSH_WORD_O = {flags_ff, flags_ff};
	assign IRQ_MASKED_O = flags_ff[`CRF_BIT_IMASK];
	assign COND_NEG_O   = flags_ff[`CRF_BIT_NEG];
	assign COND_ZERO_O  = flags_ff[`CRF_BIT_ZERO];
	assign COND_OVF_O   = flags_ff[`CRF_BIT_OVF];
	assign COND_CARRY_O = flags_ff[`CRF_BIT_CARRY];
endmodule // crf_core_state
`default_nettype wire

/* tb/crf_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ========
// far side: answers the reset vector fetch
module crf_bus_model #(
	parameter logic [15:0] VECTOR = 16'h0124,
	parameter int          DELAY  = 3
) (
	input  wire logic        clk_i,
	input  wire logic        vec_req_i,
	output var  logic        vec_ack_o,
	output var  logic [15:0] vec_data_o
);
	initial
	begin
		vec_ack_o = 1'b0;
		vec_data_o = ~VECTOR;
		forever
		begin
			@(negedge clk_i);
			if (vec_req_i === 1'b1)
			begin
				repeat (DELAY) @(negedge clk_i);
				vec_ack_o <= 1'b1;
				vec_data_o <= VECTOR;
				@(posedge clk_i);
				vec_ack_o <= 1'b0;
				vec_data_o <= ~VECTOR;
			end
		end
	end
endmodule // crf_bus_model
`default_nettype wire

/* tb/crf_core_state_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "crf_consts.vh"
module crf_core_state_checker (
	// clock and reset
	input wire logic        CLOCK_I,
	input wire logic        RESETN_I,
	// inputs watched
	input wire logic        ADDR_WORD_I,
	input wire logic        EXC_ENTRY_I,
	input wire logic        FLAG_RESTORE_I,
	input wire logic        VEC_ACK_I,
	input wire logic        PC_STEP_I,
	input wire logic        PC_LOAD_I,
	input wire logic [2:0]  FLAG_INSN_I,
	input wire logic [3:0]  FLAG_OP_I,
	input wire logic [15:0] VEC_DATA_I,
	input wire logic [15:0] FLAG_STACK_WORD_I,
	// outputs watched
	input wire logic [15:0] REG_B_DATA_O,
	input wire logic [15:0] DATA_ADDR_O,
	input wire logic [15:0] STACK_ADDR_O,
	input wire logic [15:0] FETCH_ADDR_O,
	input wire logic [15:0] PC_O,
	input wire logic [15:0] FLAG_PUSH_WORD_O,
	input wire logic [7:0]  FLAGS_O,
	input wire logic        VEC_REQ_O,
	input wire logic        RUN_O,
	input wire logic        BIT_SEL_O,
	input wire logic        IRQ_MASKED_O,
	input wire logic        COND_NEG_O,
	input wire logic        COND_ZERO_O,
	input wire logic        COND_OVF_O,
	input wire logic        COND_CARRY_O
);
	// ========
	// properties
	default clocking dc @(posedge CLOCK_I);
	endclocking
	default disable iff (!RESETN_I);
	sequence s_vec_taken;
		VEC_REQ_O && VEC_ACK_I;
	endsequence
	sequence s_run_from_vec;
		RUN_O && PC_O == $past(VEC_DATA_I);
	endsequence
	sequence s_restore;
		RUN_O && FLAG_RESTORE_I && !EXC_ENTRY_I;
	endsequence
	a_vector_load: assert property (s_vec_taken |=> s_run_from_vec)
		else $error("counter not loaded from vector");
	a_vec_req_soon: assert property ($rose(RESETN_I) |-> ##[1:8] VEC_REQ_O)
		else $error("no vector request");
	a_mask_on_exc: assert property (RUN_O && EXC_ENTRY_I |=> FLAGS_O[7] && IRQ_MASKED_O)
		else $error("mask not set on exception");
	a_restore_upper: assert property (s_restore |=> FLAGS_O == $past(FLAG_STACK_WORD_I[15:8]))
		else $error("restore not from upper byte");
	a_push_both: assert property (FLAG_PUSH_WORD_O == {FLAGS_O, FLAGS_O})
		else $error("pushed word wrong");
	a_user_bits: assert property (FLAG_INSN_I == `CRF_FI_NONE && !FLAG_RESTORE_I |=>
		$stable(FLAGS_O[6]) && $stable(FLAGS_O[4])) else $error("user bit changed");
	a_branch_conds: assert property ({COND_NEG_O, COND_ZERO_O, COND_OVF_O, COND_CARRY_O} == FLAGS_O[3:0])
		else $error("branch conditions wrong");
	a_carry_bitacc: assert property (RUN_O && FLAG_OP_I == `CRF_OP_BITACC && !FLAG_RESTORE_I &&
		FLAG_INSN_I == `CRF_FI_NONE |=> FLAGS_O[0] == $past(BIT_SEL_O)) else $error("bit not in carry");
	a_pc_step: assert property (RUN_O && PC_STEP_I && !PC_LOAD_I |=> PC_O == $past(PC_O) + 16'h0002)
		else $error("counter step wrong");
	a_fetch_even: assert property (RUN_O |-> FETCH_ADDR_O == {PC_O[15:1], 1'b0})
		else $error("fetch address wrong");
	a_word_even: assert property (ADDR_WORD_I |-> DATA_ADDR_O == {REG_B_DATA_O[15:1], 1'b0} &&
		!STACK_ADDR_O[0]) else $error("word address odd");
endmodule // crf_core_state_checker
bind crf_core_state crf_core_state_checker crf_core_state_checker_i (.*);
`default_nettype wire

/* tb/crf_core_state_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "crf_consts.vh"
module crf_core_state_tb;
	// ========
	// signals
	localparam logic [15:0] VEC = 16'h0124;
	int errors = 0, comparisons = 0, i;
	logic CLOCK_I = 0, RESETN_I = 0, REG_WR_HI_I = 0, REG_WR_LO_I = 0, REG_A_BYTE_I = 0, REG_A_LOW_I = 0;
	logic ADDR_WORD_I = 0, PC_LOAD_I = 0, PC_STEP_I = 0, FLAG_SHOUT_I = 0, BIT_INVERT_I = 0;
	logic FLAG_RESTORE_I = 0, EXC_ENTRY_I = 0, VEC_ACK_I, RUN_O, VEC_REQ_O, BIT_SEL_O, IRQ_MASKED_O;
	logic COND_NEG_O, COND_ZERO_O, COND_OVF_O, COND_CARRY_O;
	logic [2:0] REG_WR_SEL_I = 0, REG_A_SEL_I = 0, REG_B_SEL_I = 0, ADDR_SEL_I = 0, BIT_NUM_I = 0;
	logic [2:0] FLAG_INSN_I = 0;
	logic [3:0] FLAG_OP_I = 0, BCD_HI_DIGIT_O, BCD_LO_DIGIT_O;
	logic [7:0] BIT_BYTE_I = 0, FLAG_INSN_DATA_I = 0, FLAGS_O;
	logic [15:0] REG_WR_DATA_I = 0, PC_DATA_I = 0, FLAG_A_I = 0, FLAG_B_I = 0, FLAG_RES_I = 0;
	logic [15:0] FLAG_STACK_WORD_I = 0, VEC_DATA_I, REG_A_DATA_O, REG_B_DATA_O, DATA_ADDR_O;
	logic [15:0] STACK_ADDR_O, FETCH_ADDR_O, PC_O, FLAG_PUSH_WORD_O;
	crf_core_state crf_core_state_i (.*);
	crf_bus_model #(.VECTOR(VEC), .DELAY(3)) crf_bus_model_i (.clk_i(CLOCK_I), .vec_req_i(VEC_REQ_O),
		.vec_ack_o(VEC_ACK_I), .vec_data_o(VEC_DATA_I));
	initial
	begin
		forever #12.5 CLOCK_I = ~CLOCK_I;
	end
	// ========
	// helpers
	task automatic tick;
		@(negedge CLOCK_I);
	endtask
	task automatic chk(input logic [15:0] got, exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
		end
	endtask
	task automatic chkf(input logic [7:0] exp, mask);
		chk({8'h00, FLAGS_O & mask}, {8'h00, exp}, "flags");
	endtask
	task automatic wr(input logic [2:0] s, input logic [15:0] d, input logic hi, lo);
		REG_WR_SEL_I = s;
		REG_WR_DATA_I = d;
		REG_WR_HI_I = hi;
		REG_WR_LO_I = lo;
		tick;
		REG_WR_HI_I = 1'b0;
		REG_WR_LO_I = 1'b0;
	endtask
	task automatic fi(input logic [2:0] c, input logic [7:0] d, exp);
		FLAG_INSN_I = c;
		FLAG_INSN_DATA_I = d;
		tick;
		FLAG_INSN_I = `CRF_FI_NONE;
		chkf(exp, 8'hff);
	endtask
	task automatic opx(input logic [3:0] op, input logic [15:0] a, b, r, input logic so, input logic [7:0] exp, m);
		FLAG_OP_I = op;
		FLAG_A_I = a;
		FLAG_B_I = b;
		FLAG_RES_I = r;
		FLAG_SHOUT_I = so;
		tick;
		FLAG_OP_I = `CRF_OP_NONE;
		chkf(exp, m);
	endtask
	// ========
	// scenarios
	task automatic t_boot;
		FLAG_INSN_I = `CRF_FI_LOAD;
		tick;
		FLAG_INSN_I = `CRF_FI_NONE;
		for (i = 0; i < 40 && RUN_O !== 1'b1; i++)
			tick;
		chk(PC_O, VEC, "counter");
		chkf(8'h80, 8'h80);
		chk(IRQ_MASKED_O, 1'b1, "mask");
		wr(3'h7, 16'hfe0f, 1'b1, 1'b1);
		chk(STACK_ADDR_O, 16'hfe0e, "stack");
		$display("boot done");
	endtask
	task automatic t_regs;
		for (i = 0; i < 7; i++)
			wr(i[2:0], 16'h1357 + 16'(i) * 16'h1111, 1'b1, 1'b1);
		for (i = 0; i < 8; i++)
		begin
			REG_B_SEL_I = i[2:0];
			#1 chk(REG_B_DATA_O, i == 7 ? 16'hfe0f : 16'h1357 + 16'(i) * 16'h1111, "word");
		end
		wr(3'h3, 16'h3c00, 1'b1, 1'b0);
		REG_B_SEL_I = 3'h3;
		REG_A_SEL_I = 3'h3;
		REG_A_BYTE_I = 1'b1;
		REG_A_LOW_I = 1'b1;
		#1 chk(REG_B_DATA_O, 16'h3c8a, "half");
		chk(REG_A_DATA_O, 16'h008a, "low");
		REG_A_LOW_I = 1'b0;
		#1 chk(REG_A_DATA_O, 16'h003c, "high");
		REG_A_BYTE_I = 1'b0;
		#1 chk(REG_A_DATA_O, 16'h3c8a, "a word");
		$display("registers done");
	endtask
	task automatic t_addr;
		wr(3'h2, 16'h1235, 1'b1, 1'b1);
		REG_B_SEL_I = 3'h2;
		ADDR_WORD_I = 1'b1;
		#1 chk(DATA_ADDR_O, 16'h1234, "even");
		ADDR_WORD_I = 1'b0;
		#1 chk(DATA_ADDR_O, 16'h1235, "byte");
		PC_STEP_I = 1'b1;
		tick;
		PC_STEP_I = 1'b0;
		chk(PC_O, VEC + 16'h0002, "step");
		PC_LOAD_I = 1'b1;
		PC_DATA_I = 16'h4001;
		tick;
		PC_LOAD_I = 1'b0;
		chk(FETCH_ADDR_O, 16'h4000, "fetch");
		$display("addresses done");
	endtask
	task automatic t_flags;
		fi(`CRF_FI_LOAD, 8'h00, 8'h00);
		fi(`CRF_FI_OR, 8'h50, 8'h50);
		fi(`CRF_FI_XOR, 8'hff, 8'haf);
		fi(`CRF_FI_AND, 8'h5f, 8'h0f);
		EXC_ENTRY_I = 1'b1;
		tick;
		EXC_ENTRY_I = 1'b0;
		chkf(8'h8f, 8'hff);
		chk(FLAG_PUSH_WORD_O, 16'h8f8f, "push");
		FLAG_RESTORE_I = 1'b1;
		FLAG_STACK_WORD_I = 16'h5aa5;
		tick;
		FLAG_RESTORE_I = 1'b0;
		chkf(8'h5a, 8'hff);
		fi(`CRF_FI_LOAD, 8'h50, 8'h50);
		$display("flag register done");
	endtask
	task automatic t_arith;
		opx(`CRF_OP_ADD_B, 16'h007f, 16'h0001, 0, 0, 8'h7a, 8'hff);
		opx(`CRF_OP_SUB_B, 16'h0000, 16'h0001, 0, 0, 8'h79, 8'hff);
		chk({12'h000, COND_NEG_O, COND_ZERO_O, COND_OVF_O, COND_CARRY_O}, 16'h0009, "conds");
		opx(`CRF_OP_ADD_W, 16'h0fff, 16'h0001, 0, 0, 8'h70, 8'hff);
		opx(`CRF_OP_SUB_W, 16'h0000, 16'h0001, 0, 0, 8'h79, 8'hff);
		opx(`CRF_OP_LOGIC, 0, 0, 16'h0000, 0, 8'h54, 8'h5e);
		opx(`CRF_OP_SHIFT, 0, 0, 16'h0000, 0, 8'h00, 8'h01);
		opx(`CRF_OP_SHIFT, 0, 0, 16'h0000, 1, 8'h01, 8'h01);
		BIT_BYTE_I = 8'h20;
		BIT_NUM_I = 3'h4;
		opx(`CRF_OP_BITACC, 0, 0, 0, 0, 8'h00, 8'h01);
		BIT_NUM_I = 3'h5;
		#1 chk(BIT_SEL_O, 1'b1, "bit");
		opx(`CRF_OP_BITACC, 0, 0, 0, 0, 8'h01, 8'h01);
		BIT_INVERT_I = 1'b1;
		opx(`CRF_OP_BITACC, 0, 0, 0, 0, 8'h00, 8'h01);
		FLAG_RES_I = 16'h0093;
		#1 chk({8'h00, BCD_HI_DIGIT_O, BCD_LO_DIGIT_O}, 16'h0093, "digits");
		$display("arithmetic done");
	endtask
	// ========
	// run control
	task automatic give_verdict;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (12) tick;
		RESETN_I = 1'b1;
		t_boot;
		t_regs;
		t_addr;
		t_flags;
		t_arith;
		give_verdict;
	end
	// tests need well under 300 cycles
	initial
	begin
		repeat (3000) @(posedge CLOCK_I);
		errors++;
		give_verdict;
	end
endmodule // crf_core_state_tb
`default_nettype wire
